// ==== hw/iox_regs.svh ====
// Constants for the I/O expander serial target: addresses, codes, timing counts
`ifndef IOX_REGS_SVH
`define IOX_REGS_SVH

// Fixed upper part of the 7-bit target address
`define IOX_DEV_ADDR_HI   5'b01000
// Reserved address that carries the software reset command
`define IOX_GC_ADDR       7'h00
// Data byte that arms the software reset
`define IOX_SWRST_CODE    8'h06
// Bits in one byte on the wire
`define IOX_BYTE_BITS     4'd8
// Last bit index of a transmitted byte
`define IOX_TX_LAST       4'd7
// Widest spike the line filter must swallow, in ns
`define IOX_SPIKE_NS      50
// Period of the link sampling clock, in ns
`define IOX_LINK_NS       64
// Filter length in link cycles: spike time rounded up, at least one cycle
`define IOX_FILT_CYC      ((((`IOX_SPIKE_NS) + (`IOX_LINK_NS) - 1) / (`IOX_LINK_NS)) < 1 ? 1 : \
	(((`IOX_SPIKE_NS) + (`IOX_LINK_NS) - 1) / (`IOX_LINK_NS)))
// Width of the filter counter
`define IOX_FCW           3

`endif

// ==== hw/iox_pkg.sv ====
// Types shared by the I/O expander serial target and its register file
package iox_pkg;

	// Register access request carried from the link side to the system side
	typedef struct packed {
		logic       wr;
		logic       loop_sel;
		logic [6:0] addr;
		logic [7:0] data;
	} iox_req_t;

	// Register file answer: ok low marks a reserved location
	typedef struct packed {
		logic       ok;
		logic [7:0] rdata;
	} iox_ans_t;

	// Protocol engine states
	typedef enum logic [2:0] {
		IOX_IDLE,
		IOX_ADDR,
		IOX_RX,
		IOX_ACK,
		IOX_TX,
		IOX_MACK
	} iox_state_t;

endpackage : iox_pkg

// ==== hw/iox_i2c_target.sv ====
// Serial target interface of the 16-bit I/O expander: framing, addressing, register access
`include "iox_regs.svh"
module iox_i2c_target (
	// System clock and power-on reset
	input  wire logic           clock,
	input  wire logic           rst_b,
	// Link sampling clock
	input  wire logic           link_clk,
	// Bus pins
	input  wire logic           scl_i,
	input  wire logic           sda_i,
	output logic                sda_o,
	output logic                sda_oe_b,
	input  wire logic           addr_pin_i,
	input  wire logic           rst_pin_b,
	// Register file access
	output iox_pkg::iox_req_t   reg_req,
	output logic                reg_req_valid,
	input  wire iox_pkg::iox_ans_t reg_ans,
	input  wire logic           reg_ans_valid,
	output logic                regs_clear
);
	import iox_pkg::*;

	// Link-domain reset: asserted with rst_b, released on the link clock
	logic [1:0] lrst_r;
	logic       lrst_b;

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			lrst_r <= 2'b00;
		end else begin
			lrst_r <= {lrst_r[0], 1'b1};
		end
	end
	assign lrst_b = lrst_r[1];

	// Two-flop synchronisers and spike filters for clock, data and strap
	logic [2:0] pin_raw;
	logic [2:0] pin_f;

	assign pin_raw = {addr_pin_i, sda_i, scl_i};

	genvar gi;
	for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
		logic                s1_r;
		logic                s2_r;
		logic                f_r;
		logic [`IOX_FCW-1:0] cnt_r;

		// Synchroniser pair
		always_ff @(posedge link_clk or negedge lrst_b) begin
			if (!lrst_b) begin
				s1_r <= 1'b1;
				s2_r <= 1'b1;
			end else begin
				s1_r <= pin_raw[gi];
				s2_r <= s1_r;
			end
		end

		// Level follows only after it differs for a full filter span
		always_ff @(posedge link_clk or negedge lrst_b) begin
			if (!lrst_b) begin
				f_r   <= 1'b1;
				cnt_r <= '0;
			end else if (s2_r == f_r) begin
				cnt_r <= '0;
			end else if (cnt_r == `IOX_FCW'(`IOX_FILT_CYC)) begin
				f_r   <= s2_r;
				cnt_r <= '0;
			end else begin
				cnt_r <= cnt_r + `IOX_FCW'(1);
			end
		end
		assign pin_f[gi] = f_r;
	end

	// Bus condition detection on filtered lines
	logic scl_f;
	logic sda_f;
	logic addr_f;
	logic scl_d_r;
	logic sda_d_r;
	logic scl_rise;
	logic scl_fall;
	logic start_evt;
	logic stop_evt;

	assign scl_f  = pin_f[0];
	assign sda_f  = pin_f[1];
	assign addr_f = pin_f[2];

	always_ff @(posedge link_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_f;
			sda_d_r <= sda_f;
		end
	end

	assign scl_rise  = scl_f & ~scl_d_r;
	assign scl_fall  = ~scl_f & scl_d_r;
	assign start_evt = scl_f & scl_d_r & sda_d_r & ~sda_f;
	assign stop_evt  = scl_f & scl_d_r & ~sda_d_r & sda_f;

	// Strap sampling: idle bus, at start, and at first clock low after start
	logic       strap_idle_r;
	logic       strap_start_r;
	logic       strap_low_r;
	logic       strap_wait_r;
	logic [1:0] own_lo;
	logic [6:0] own_addr;

	always_ff @(posedge link_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			strap_idle_r  <= 1'b0;
			strap_start_r <= 1'b0;
			strap_low_r   <= 1'b0;
			strap_wait_r  <= 1'b0;
		end else if (start_evt) begin
			strap_start_r <= addr_f;
			strap_wait_r  <= 1'b1;
		end else begin
			if (scl_f && sda_f) begin
				strap_idle_r <= addr_f;
			end
			if (strap_wait_r && scl_fall) begin
				strap_low_r  <= addr_f;
				strap_wait_r <= 1'b0;
			end
		end
	end

	// Ground, supply, clock line and data line connections decoded
	always_comb begin
		if (!strap_idle_r) begin
			own_lo = 2'b00;
		end else if (!strap_start_r) begin
			own_lo = 2'b11;
		end else if (strap_low_r) begin
			own_lo = 2'b01;
		end else begin
			own_lo = 2'b10;
		end
	end
	assign own_addr = {`IOX_DEV_ADDR_HI, own_lo};

	// Answer crossing from the system side
	logic     ans_tgl_c_r;
	iox_ans_t ans_hold_r;
	logic [2:0] ans_sync_r;
	logic     ans_evt;

	always_ff @(posedge link_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			ans_sync_r <= 3'h0;
		end else begin
			ans_sync_r <= {ans_sync_r[1:0], ans_tgl_c_r};
		end
	end
	assign ans_evt = ans_sync_r[2] ^ ans_sync_r[1];

	// Protocol engine
	iox_state_t state_r;
	logic [3:0] bitcnt_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic [6:0] ptr_r;
	logic       loop_r;
	logic       ptr_set_r;
	logic       rw_r;
	logic       gc_r;
	logic       ack_r;
	logic       wdat_r;
	logic       wr_pend_r;
	logic       mack_r;
	logic       swrst_arm_r;
	logic       swrst_tgl_r;
	logic       req_tgl_r;
	iox_req_t   req_pl_r;
	logic [7:0] rbuf_r;
	logic       rok_r;

	always_ff @(posedge link_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			state_r     <= IOX_IDLE;
			bitcnt_r    <= 4'h0;
			sh_r        <= 8'h00;
			tx_r        <= 8'hff;
			ptr_r       <= 7'h00;
			loop_r      <= 1'b0;
			ptr_set_r   <= 1'b0;
			rw_r        <= 1'b0;
			gc_r        <= 1'b0;
			ack_r       <= 1'b0;
			wdat_r      <= 1'b0;
			wr_pend_r   <= 1'b0;
			mack_r      <= 1'b0;
			swrst_arm_r <= 1'b0;
			swrst_tgl_r <= 1'b0;
			req_tgl_r   <= 1'b0;
			req_pl_r    <= '0;
		end else if (stop_evt) begin
			state_r     <= IOX_IDLE;
			ack_r       <= 1'b0;
			wr_pend_r   <= 1'b0;
			swrst_arm_r <= 1'b0;
			if (swrst_arm_r) begin
				swrst_tgl_r <= ~swrst_tgl_r;
			end
		end else if (start_evt) begin
			state_r     <= IOX_ADDR;
			bitcnt_r    <= 4'h0;
			ack_r       <= 1'b0;
			gc_r        <= 1'b0;
			ptr_set_r   <= 1'b0;
			wr_pend_r   <= 1'b0;
			swrst_arm_r <= 1'b0;
		end else begin
			if (ans_evt && wr_pend_r) begin
				ack_r     <= ans_hold_r.ok;
				wr_pend_r <= 1'b0;
			end
			case (state_r)
				IOX_ADDR, IOX_RX: begin
					if (scl_rise) begin
						sh_r     <= {sh_r[6:0], sda_f};
						bitcnt_r <= bitcnt_r + 4'h1;
						// Launch a data write on its last bit so the answer beats the ack clock
						if (state_r == IOX_RX && !gc_r && ptr_set_r &&
							bitcnt_r == `IOX_TX_LAST) begin
							wr_pend_r <= 1'b1;
							req_tgl_r <= ~req_tgl_r;
							req_pl_r  <= '{wr: 1'b1, loop_sel: loop_r,
								addr: ptr_r, data: {sh_r[6:0], sda_f}};
						end
					end else if (scl_fall && bitcnt_r == `IOX_BYTE_BITS) begin
						bitcnt_r <= 4'h0;
						wdat_r   <= 1'b0;
						state_r  <= IOX_ACK;
						if (state_r == IOX_ADDR) begin
							if (sh_r[7:1] == own_addr) begin
								ack_r <= 1'b1;
								rw_r  <= sh_r[0];
								if (sh_r[0]) begin
									req_tgl_r <= ~req_tgl_r;
									req_pl_r  <= '{wr: 1'b0, loop_sel: loop_r,
										addr: ptr_r, data: 8'h00};
								end
							end else if (sh_r == {`IOX_GC_ADDR, 1'b0}) begin
								ack_r <= 1'b1;
								gc_r  <= 1'b1;
								rw_r  <= 1'b0;
							end else begin
								state_r <= IOX_IDLE;
							end
						end else if (gc_r) begin
							ptr_set_r <= 1'b1;
							if (!ptr_set_r && sh_r == `IOX_SWRST_CODE) begin
								ack_r       <= 1'b1;
								swrst_arm_r <= 1'b1;
							end else begin
								ack_r       <= 1'b0;
								swrst_arm_r <= 1'b0;
							end
						end else if (!ptr_set_r) begin
							ptr_r     <= sh_r[6:0];
							loop_r    <= sh_r[7];
							ptr_set_r <= 1'b1;
							ack_r     <= 1'b1;
						end else begin
							wdat_r <= 1'b1;
						end
					end
				end
				IOX_ACK: begin
					if (scl_fall) begin
						ack_r <= 1'b0;
						if (ack_r && wdat_r) begin
							ptr_r <= ptr_r + 7'h01;
						end
						if (rw_r) begin
							tx_r      <= rok_r ? rbuf_r : 8'hff;
							bitcnt_r  <= 4'h0;
							state_r   <= IOX_TX;
							req_tgl_r <= ~req_tgl_r;
							req_pl_r  <= '{wr: 1'b0, loop_sel: loop_r,
								addr: ptr_r + 7'h01, data: 8'h00};
						end else begin
							state_r <= IOX_RX;
						end
					end
				end
				IOX_TX: begin
					if (scl_fall) begin
						if (bitcnt_r == `IOX_TX_LAST) begin
							state_r  <= IOX_MACK;
							bitcnt_r <= 4'h0;
						end else begin
							tx_r     <= {tx_r[6:0], 1'b1};
							bitcnt_r <= bitcnt_r + 4'h1;
						end
					end
				end
				IOX_MACK: begin
					if (scl_rise) begin
						mack_r <= ~sda_f;
					end else if (scl_fall) begin
						if (mack_r) begin
							ptr_r     <= ptr_r + 7'h01;
							tx_r      <= rok_r ? rbuf_r : 8'hff;
							state_r   <= IOX_TX;
							req_tgl_r <= ~req_tgl_r;
							req_pl_r  <= '{wr: 1'b0, loop_sel: loop_r,
								addr: ptr_r + 7'h02, data: 8'h00};
						end else begin
							state_r <= IOX_IDLE;
						end
					end
				end
				IOX_IDLE: begin
					bitcnt_r <= 4'h0;
				end
				default: begin
					state_r <= IOX_IDLE;
				end
			endcase
		end
	end

	// Prefetched read data for the next byte to send
	always_ff @(posedge link_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			rbuf_r <= 8'hff;
			rok_r  <= 1'b0;
		end else if (ans_evt && !wr_pend_r) begin
			rbuf_r <= ans_hold_r.rdata;
			rok_r  <= ans_hold_r.ok;
		end
	end

	// Data line drive: ack low, or a zero bit while sending
	logic sda_low_r;

	always_ff @(posedge link_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			sda_low_r <= 1'b0;
		end else begin
			sda_low_r <= (state_r == IOX_ACK && ack_r) || (state_r == IOX_TX && !tx_r[7]);
		end
	end
	assign sda_o    = 1'b0;
	assign sda_oe_b = ~sda_low_r;

	// System side: request crossing into the clock domain
	logic [2:0] req_sync_r;
	iox_req_t   reg_req_r;
	logic       reg_req_valid_r;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			req_sync_r <= 3'h0;
		end else begin
			req_sync_r <= {req_sync_r[1:0], req_tgl_r};
		end
	end

	// Payload is stable while the toggle is in flight
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_req_r       <= '0;
			reg_req_valid_r <= 1'b0;
		end else begin
			reg_req_valid_r <= req_sync_r[2] ^ req_sync_r[1];
			if (req_sync_r[2] ^ req_sync_r[1]) begin
				reg_req_r <= req_pl_r;
			end
		end
	end
	assign reg_req       = reg_req_r;
	assign reg_req_valid = reg_req_valid_r;

	// Answer capture and toggle back to the link side
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ans_hold_r  <= '0;
			ans_tgl_c_r <= 1'b0;
		end else if (reg_ans_valid) begin
			ans_hold_r  <= reg_ans;
			ans_tgl_c_r <= ~ans_tgl_c_r;
		end
	end

	// Reset pin and software reset crossing; register clear output
	logic [1:0] rpin_sync_r;
	logic [2:0] swr_sync_r;
	logic       regs_clear_r;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rpin_sync_r <= 2'b11;
			swr_sync_r  <= 3'h0;
		end else begin
			rpin_sync_r <= {rpin_sync_r[0], rst_pin_b};
			swr_sync_r  <= {swr_sync_r[1:0], swrst_tgl_r};
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			regs_clear_r <= 1'b1;
		end else begin
			regs_clear_r <= ~rpin_sync_r[1] | (swr_sync_r[2] ^ swr_sync_r[1]);
		end
	end
	assign regs_clear = regs_clear_r;

endmodule : iox_i2c_target

// ==== verif/iox_monitor.sv ====
// Port checker for the serial target, bound to its top module
module iox_mon (
	// Clocks and reset
	input wire logic              clock,
	input wire logic              rst_b,
	input wire logic              link_clk,
	// Bus pins
	input wire logic              scl_i,
	input wire logic              sda_i,
	input wire logic              sda_o,
	input wire logic              sda_oe_b,
	input wire logic              addr_pin_i,
	input wire logic              rst_pin_b,
	// Register side
	input wire iox_pkg::iox_req_t reg_req,
	input wire logic              reg_req_valid,
	input wire iox_pkg::iox_ans_t reg_ans,
	input wire logic              reg_ans_valid,
	input wire logic              regs_clear
);
	timeunit 1ns;
	timeprecision 1ns;
	import iox_pkg::*;
	logic pend_r;

	// Tracks a request still waiting for its answer
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			pend_r <= 1'b0;
		else if (reg_req_valid)
			pend_r <= 1'b1;
		else if (reg_ans_valid)
			pend_r <= 1'b0;
	end

	// Bus conditions seen on the raw pins
	sequence s_start;
		scl_i && $fell(sda_i);
	endsequence
	sequence s_stop;
		scl_i && $rose(sda_i);
	endsequence

	// Pin side
	a_start_quiet: assert property (@(posedge link_clk) disable iff (!rst_b)
		s_start |-> sda_oe_b[*8]) else $error("data driven after start");
	a_stop_quiet: assert property (@(posedge link_clk) disable iff (!rst_b)
		s_stop |-> sda_oe_b[*8]) else $error("data driven after stop");
	a_hold_high: assert property (@(posedge link_clk) disable iff (!rst_b)
		scl_i && $past(scl_i) |-> $stable(sda_oe_b)) else $error("data moved with clock high");
	a_drive_zero: assert property (@(posedge link_clk) disable iff (!rst_b)
		!sda_oe_b |-> !sda_o) else $error("data driven high");

	// Register side
	a_power_clear: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(rst_b) |-> regs_clear) else $error("no clear at power reset");
	a_pin_clear: assert property (@(posedge clock) disable iff (!rst_b)
		!rst_pin_b[*4] |-> regs_clear) else $error("no clear on reset pin");
	a_soft_pulse: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(regs_clear) && rst_pin_b |=> !regs_clear) else $error("soft clear not a pulse");
	a_req_pulse: assert property (@(posedge clock) disable iff (!rst_b)
		reg_req_valid |=> !reg_req_valid) else $error("request longer than a cycle");
	a_req_stable: assert property (@(posedge clock) disable iff (!rst_b)
		!reg_req_valid |-> $stable(reg_req)) else $error("request moved without valid");
	a_single_out: assert property (@(posedge clock) disable iff (!rst_b)
		reg_req_valid |-> !pend_r) else $error("second request outstanding");
endmodule : iox_mon

bind iox_i2c_target iox_mon u_mon (.clock, .rst_b, .link_clk, .scl_i, .sda_i, .sda_o,
	.sda_oe_b, .addr_pin_i, .rst_pin_b, .reg_req, .reg_req_valid, .reg_ans, .reg_ans_valid,
	.regs_clear);

// ==== verif/iox_bus_master.sv ====
// Behavioural bus master: makes the clock and drives data open-drain
module iox_mst (
	// Bus lines
	output logic scl,
	output logic sda_m,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	int q = 625; // Quarter bit time
	bit glit = 1'b0; // Adds spikes shorter than the filter

	// Idle bus, data released to the pull-up
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end

	// One clock pulse; with glit clear, data changes only while the clock is low
	task automatic bit_io(input logic b, output logic s);
		sda_m = b;
		if (glit) begin
			#(q/2) scl = 1'b1;
			#40 scl = 1'b0;
		end
		#q scl = 1'b1;
		#(q/2);
		if (glit && !b) begin
			sda_m = 1'b1;
			#40 sda_m = 1'b0;
		end
		#(q/2) s = sda;
		#q scl = 1'b0;
		#q;
	endtask : bit_io

	// Start or repeated start from an idle or low clock
	task automatic start_c();
		sda_m = 1'b1;
		#q scl = 1'b1;
		#q sda_m = 1'b0;
		#q scl = 1'b0;
		#q;
	endtask : start_c

	// Stop, then bus left idle
	task automatic stop_c();
		sda_m = 1'b0;
		#q scl = 1'b1;
		#q sda_m = 1'b1;
		#(2*q);
	endtask : stop_c

	// Byte out, top bit first, then the ninth acknowledge clock
	task automatic wb(input logic [7:0] d, output logic nak);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, nak);
	endtask : wb

	// Byte in, then own acknowledge or not
	task automatic rb(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!mack, s);
	endtask : rb
endmodule : iox_mst

// ==== verif/testbench.sv ====
// Self-checking bench for the serial target
`include "iox_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import iox_pkg::*;
	logic       clock = 1'b0;
	logic       link_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       rst_pin_b = 1'b1;
	logic       scl_i, sda_m, sda_o, sda_oe_b, nak, reg_req_valid, regs_clear;
	logic       reg_ans_valid = 1'b0;
	logic       clr_d = 1'b0;
	logic       pend = 1'b0;
	logic [1:0] strap = 2'h0;
	logic [7:0] mem [128];
	logic [7:0] want [128];
	iox_req_t   reg_req, rq;
	iox_ans_t   reg_ans = '0;
	wire        sda_i = sda_m & (sda_oe_b | sda_o);
	wire        addr_pin_i = strap[1] ? (strap[0] ? sda_i : scl_i) : strap[0];
	integer     seed = 32'h914f6736;
	int         failures = 0, samples_checked = 0, clr_n = 0, dly = 0, p, n;
	bit         exp_loop = 1'b0;

	// System and link clocks, unrelated in phase
	always #25 clock = ~clock;
	always #32 link_clk = ~link_clk;

	iox_i2c_target u_dut (.clock, .rst_b, .link_clk, .scl_i, .sda_i, .sda_o, .sda_oe_b,
		.addr_pin_i, .rst_pin_b, .reg_req, .reg_req_valid, .reg_ans, .reg_ans_valid, .regs_clear);
	iox_mst u_mst (.scl(scl_i), .sda_m, .sda(sda_i));

	function automatic void check(string nm, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (e !== g) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endfunction : check

	function automatic void ack_is(string nm, logic e);
		check(nm, {7'h0, !e}, {7'h0, nak});
	endfunction : ack_is

	// Places that exist in the register file
	function automatic logic okay(logic [6:0] a);
		return a < 7'h08 || (a >= 7'h40 && a <= 7'h5c && a != 7'h4e);
	endfunction : okay

	// Register file partner with a random answer delay; counts clear pulses
	always @(posedge clock) begin
		reg_ans_valid <= 1'b0;
		if (reg_req_valid) begin
			rq <= reg_req;
			pend <= 1'b1;
			dly <= $random(seed) & 1; // Short enough for data acks at 1 MHz
			check("loop_sel", {7'h0, exp_loop}, {7'h0, reg_req.loop_sel});
		end else if (pend && dly > 0) begin
			dly <= dly - 1;
		end else if (pend) begin
			pend <= 1'b0;
			reg_ans_valid <= 1'b1;
			reg_ans <= {okay(rq.addr), mem[rq.addr]};
			if (rq.wr && okay(rq.addr))
				mem[rq.addr] <= rq.data;
		end
		if (rst_b && regs_clear && !clr_d)
			clr_n++;
		clr_d <= regs_clear;
	end

	task automatic wr(input logic [1:0] lo, input logic [7:0] pt, input int cnt);
		logic [7:0] v;
		logic [6:0] a;
		a = pt[6:0];
		exp_loop = pt[7];
		u_mst.start_c();
		u_mst.wb({`IOX_DEV_ADDR_HI, lo, 1'b0}, nak);
		ack_is("waddr_ack", lo == strap);
		if (lo == strap) begin
			u_mst.wb(pt, nak);
			ack_is("ptr_ack", 1'b1);
			repeat (cnt) begin
				v = 8'($random(seed));
				u_mst.wb(v, nak);
				ack_is("data_ack", okay(a));
				if (okay(a))
					want[a] = v;
				a++;
			end
		end
		u_mst.stop_c();
	endtask : wr

	task automatic rd(input logic [1:0] lo, input logic [7:0] pt, input int cnt);
		logic [7:0] v;
		logic [6:0] a;
		a = pt[6:0];
		exp_loop = pt[7];
		u_mst.start_c();
		u_mst.wb({`IOX_DEV_ADDR_HI, strap, 1'b0}, nak);
		u_mst.wb(pt, nak);
		u_mst.start_c();
		u_mst.wb({`IOX_DEV_ADDR_HI, lo, 1'b1}, nak);
		ack_is("raddr_ack", lo == strap);
		for (int i = 0; i < cnt && lo == strap; i++) begin
			u_mst.rb(i < cnt - 1, v);
			check("rdata", okay(a) ? want[a] : 8'hff, v);
			a++;
		end
		u_mst.stop_c();
	endtask : rd

	task automatic gc(input logic [7:0] c, input bit more, input bit rs, input int inc);
		int n0;
		n0 = clr_n;
		u_mst.start_c();
		u_mst.wb({`IOX_GC_ADDR, 1'b0}, nak);
		ack_is("gc_addr", 1'b1);
		u_mst.wb(c, nak);
		ack_is("gc_code", c == `IOX_SWRST_CODE);
		if (more)
			u_mst.wb(c, nak);
		if (more)
			ack_is("gc_more", 1'b0);
		if (rs)
			u_mst.start_c();
		u_mst.stop_c();
		repeat (10) @(posedge clock);
		check("soft_clear", 8'(n0 + inc), 8'(clr_n));
	endtask : gc

	task automatic test_done();
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// Main sequence
	initial begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'($random(seed));
		want = mem;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (20) @(posedge clock);
		for (int s = 0; s < 4; s++) begin
			@(posedge clock);
			strap <= 2'(s);
			@(posedge clock);
			wr(2'(s), 8'h02, 3);
			rd(2'(s), 8'h02, 3);
			wr(2'(s) ^ 2'h1, 8'h04, 1);
		end
		wr(strap, 8'hc0, 3);
		rd(strap, 8'hc0, 3);
		rd(2'h0, 8'h02, 1);
		wr(strap, 8'h4d, 2);
		rd(strap, 8'h4c, 4);
		gc(`IOX_SWRST_CODE, 1'b0, 1'b0, 1);
		gc(`IOX_SWRST_CODE, 1'b1, 1'b0, 0);
		gc(8'h05, 1'b0, 1'b0, 0);
		gc(`IOX_SWRST_CODE, 1'b0, 1'b1, 0);
		@(posedge clock);
		rst_pin_b <= 1'b0;
		repeat (10) @(posedge clock);
		check("pin_clear", 8'h1, {7'h0, regs_clear});
		rst_pin_b <= 1'b1;
		repeat (10) @(posedge clock);
		check("pin_release", 8'h0, {7'h0, regs_clear});
		u_mst.glit = 1'b1;
		wr(strap, 8'h05, 2);
		rd(strap, 8'h05, 2);
		u_mst.glit = 1'b0;
		u_mst.q = 250;
		wr(strap, 8'h40, 2);
		rd(strap, 8'h40, 3);
		u_mst.q = 2500;
		rd(strap, 8'h40, 2);
		u_mst.q = 625;
		repeat (6) begin
			@(posedge clock);
			strap <= 2'($random(seed));
			@(posedge clock);
			p = {$random(seed)} % 5;
			n = 1 + {$random(seed)} % 3;
			wr(strap, 8'(p), n);
			rd(strap, 8'(p), n);
		end
		check("clear_count", 8'h2, 8'(clr_n));
		test_done();
	end

	// Watchdog against a hung transfer
	initial begin
		#5000000;
		failures++;
		test_done();
	end
endmodule : testbench
